/* bench/test_twr_register_bank.sv */
/*
  test_twr_register_bank: self-checking bench for the register bank.
  assumes: twr_host_model plays the host; twr_bank_props is bound below.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module test_twr_register_bank;
  logic i_ref_clk, i_arst_n, i_power_off_pin_n;
  logic i_if_phase_lead, i_if_locked, i_rf_phase_lead, i_rf_locked;
  logic sclk, sdata, sel_n;
  twr_pkg::twr_regs_t o_regs, exp_regs;
  twr_pkg::twr_ratios_t o_ratios;
  twr_pkg::twr_pump_t o_pump;
  logic o_serial_active, o_functions_on, lo_en, lo_div2, vco_high, port_high;
  int err_total, total_checks;
  logic [15:0] seed;
  logic [23:0] w;

  twr_register_bank twr_register_bank_i (
    .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_sclk(sclk), .i_sdata(sdata), .i_sel_n(sel_n),
    .i_power_off_pin_n(i_power_off_pin_n), .i_if_phase_lead(i_if_phase_lead), .i_if_locked(i_if_locked),
    .i_rf_phase_lead(i_rf_phase_lead), .i_rf_locked(i_rf_locked), .o_regs(o_regs), .o_ratios(o_ratios),
    .o_pump(o_pump), .o_serial_active(o_serial_active), .o_functions_on(o_functions_on),
    .o_buffered_lo_output_en(lo_en), .o_buffered_lo_div2(lo_div2), .o_if_vco_high(vco_high),
    .o_if_port_high(port_high)
  );
  twr_host_model twr_host_model_i (.i_ref_clk(i_ref_clk), .o_sclk(sclk), .o_sdata(sdata), .o_sel_n(sel_n));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic twr_pkg::twr_regs_t apply(input twr_pkg::twr_regs_t r, input logic [23:0] v);
    case (v[3:0])
      4'h0: r.rf_main_divider = v[23:4];
      4'h1: r.rf_reference_divider = v[23:4];
      4'h2: r.if_main_divider = v[23:4];
      4'h3: r.if_reference_divider = v[23:4];
      4'h4: r.operation_control = v[23:4];
      4'h5: r.pll_setup_options = v[23:4];
      4'h7: r.test_mode_control = v[23:4];
      default: r = r;
    endcase
    if (v[3:0] == 4'h4 && !v[4]) r = twr_pkg::REGS_DEFAULT;
    return r;
  endfunction : apply

  task automatic summarize;
    $display("errors %0d checks %0d", err_total, total_checks);
    if (err_total == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize

  // only whole words are expected to land, and none while the pin is low
  task automatic wr(input logic [23:0] v, input int n = 24);
    twr_host_model_i.send(v, n, 1'b0);
    if (n == 24 && i_power_off_pin_n) exp_regs = apply(exp_regs, v);
    `CHK(o_regs, exp_regs)
  endtask : wr

  task automatic wait_active;
    for (int k = 0; k < 20 && o_serial_active !== 1'b1; k++) @(negedge i_ref_clk);
    if (o_serial_active !== 1'b1) begin
      err_total++;
      summarize();
    end else begin
      repeat (4) @(negedge i_ref_clk);
    end
  endtask : wait_active

  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end

  initial begin
    #400_000;
    err_total++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_arst_n = 1'b0;
    i_power_off_pin_n = 1'b1;
    {i_if_phase_lead, i_if_locked, i_rf_phase_lead, i_rf_locked} = 4'h0;
    err_total = 0;
    total_checks = 0;
    seed = 16'h521e;
    exp_regs = twr_pkg::REGS_DEFAULT;
    repeat (8) @(negedge i_ref_clk);
    i_arst_n = 1'b1;
    `CHK(o_regs, exp_regs)
    wait_active();
    // turbo window opened by a divider write, closed by the second lead/lag change (rf) or by lock (if)
    wr(24'h00_0120);
    `CHK(o_pump.rf_fast_acquire, 1'b1)
    i_rf_phase_lead = 1'b1;
    repeat (8) @(negedge i_ref_clk);
    `CHK(o_pump.rf_fast_acquire, 1'b1)
    i_rf_phase_lead = 1'b0;
    repeat (8) @(negedge i_ref_clk);
    `CHK(o_pump.rf_fast_acquire, 1'b0)
    wr(24'h00_0122);
    `CHK(o_pump.if_fast_acquire, 1'b1)
    i_if_locked = 1'b1;
    repeat (8) @(negedge i_ref_clk);
    `CHK(o_pump.if_fast_acquire, 1'b0)
    i_if_locked = 1'b0;
    // hold-max keeps the boost past lock; clearing it lets lock end the boost
    i_rf_locked = 1'b1;
    wr(24'h0c_92f4);
    `CHK(o_pump.rf_fast_acquire, 1'b1)
    wr(24'h08_92f4);
    `CHK(o_pump.rf_fast_acquire, 1'b0)
    i_rf_locked = 1'b0;
    // refused traffic: short, long, select high, unmapped
    wr(24'h12_3450, 23);
    wr(24'h12_3450, 25);
    twr_host_model_i.send(24'hff_fff0, 24, 1'b1);
    `CHK(o_regs, exp_regs)
    wr(24'h12_3456);
    // soft off, then standby, then back on with the lo buffer
    wr(24'h08_92e4);
    `CHK(o_functions_on, 1'b0)
    wr(24'h00_0450);
    wr(24'h08_92f4);
    `CHK(o_functions_on, 1'b1)
    wr(24'h08_92b4);
    `CHK(o_functions_on, 1'b0)
    wr(24'h08_93f4);
    `CHK({o_functions_on, lo_en}, 2'h3)
    wr(24'h0d_83f5);
    `CHK(lo_div2, 1'b1)
    // hardware pin low: defaults held and words ignored
    i_power_off_pin_n = 1'b0;
    repeat (8) @(negedge i_ref_clk);
    exp_regs = twr_pkg::REGS_DEFAULT;
    `CHK(o_serial_active, 1'b0)
    wr(24'h00_0450);
    i_power_off_pin_n = 1'b1;
    wait_active();
    repeat (40) begin
      seed = lfsr(seed);
      w[23:8] = seed;
      seed = lfsr(seed);
      w[7:0] = seed[7:0];
      if (w[3:0] == 4'h4) w[4] = |seed[9:8];
      {i_if_phase_lead, i_rf_phase_lead, i_rf_locked} = seed[12:10];
      wr(w);
      `CHK(o_ratios.if_ref_ratio, exp_regs.if_reference_divider[10:0])
      `CHK(o_ratios.if_main_ratio, exp_regs.if_main_divider[13:0])
      `CHK({o_pump.if_pump_current, o_pump.rf_pump_current}, exp_regs.pll_setup_options[9:6])
      `CHK(o_ratios.rf_main_ratio, exp_regs.rf_main_divider[17:0])
      `CHK(o_ratios.rf_ref_ratio, exp_regs.rf_reference_divider[12:0])
      `CHK({port_high, vco_high}, exp_regs.operation_control[10:9])
    end
    summarize();
  end
endmodule : test_twr_register_bank

bind twr_register_bank twr_bank_props twr_bank_props_i (
  .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_sel_n(i_sel_n), .i_rf_locked(i_rf_locked),
  .o_regs(o_regs), .o_ratios(o_ratios), .o_pump(o_pump), .o_serial_active(o_serial_active),
  .o_functions_on(o_functions_on), .o_buffered_lo_output_en(o_buffered_lo_output_en),
  .o_buffered_lo_div2(o_buffered_lo_div2), .o_if_vco_high(o_if_vco_high), .o_if_port_high(o_if_port_high)
);

/* bench/twr_bank_props.sv */
/*
  twr_bank_props: concurrent checks on the register bank ports.
  assumes: bound to twr_register_bank from the bench top file; one clock domain.
*/
`timescale 1ns/1ps
module twr_bank_props (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_sel_n,
  input wire logic i_rf_locked,
  input wire twr_pkg::twr_regs_t o_regs,
  input wire twr_pkg::twr_ratios_t o_ratios,
  input wire twr_pkg::twr_pump_t o_pump,
  input wire logic o_serial_active,
  input wire logic o_functions_on,
  input wire logic o_buffered_lo_output_en,
  input wire logic o_buffered_lo_div2,
  input wire logic o_if_vco_high,
  input wire logic o_if_port_high
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_arst_n);

  ////////////////////////////////////////////////////////////////////////////
  // lo_enable_a through pump_level_a guarded by stable registers so a one-cycle output register is tolerated
  lo_enable_a: assert property (
    $stable(o_regs) && $stable(o_functions_on) |->
    o_buffered_lo_output_en == (o_functions_on && o_regs.operation_control[twr_pkg::OP_BUF_ENABLE]))
    else $error("lo buffer enable wrong");
  lo_divide_a: assert property (
    $stable(o_regs) |-> o_buffered_lo_div2 == o_regs.pll_setup_options[twr_pkg::CF_BUF_DIV2])
    else $error("lo divide select wrong");
  vco_port_a: assert property (
    $stable(o_regs) |-> {o_if_port_high, o_if_vco_high} == o_regs.operation_control[10:9])
    else $error("vco band or port select wrong");
  ratio_slice_a: assert property (
    $stable(o_regs) |-> o_ratios == {o_regs.rf_main_divider[17:0], o_regs.rf_reference_divider[12:0],
    o_regs.if_main_divider[13:0], o_regs.if_reference_divider[10:0]})
    else $error("divide ratio slice wrong");
  pump_level_a: assert property (
    $stable(o_regs) |-> {o_pump.if_pump_current, o_pump.rf_pump_current} == o_regs.pll_setup_options[9:6])
    else $error("pump current field wrong");
  power_gate_a: assert property (
    o_functions_on |-> o_regs.operation_control[0] && o_regs.operation_control[2] && o_serial_active)
    else $error("functions on while off");
  pin_defaults_a: assert property (
    !o_serial_active && !$past(o_serial_active) |-> o_regs == twr_pkg::REGS_DEFAULT)
    else $error("registers kept while pin low");
  // a word lands about three cycles after select rises, never otherwise
  latch_timing_a: assert property (
    o_serial_active && $past(o_serial_active) && $changed(o_regs) |->
    i_sel_n && $past(i_sel_n, 2) && !$past(i_sel_n, 5))
    else $error("register changed without select rise");
  turbo_cause_a: assert property (
    o_pump.rf_fast_acquire |-> $past(o_regs.pll_setup_options[2]) && $past(o_functions_on))
    else $error("turbo without enable");
  turbo_lock_a: assert property (
    (i_rf_locked && !o_regs.operation_control[14] && $stable(o_regs))[*8] |-> !o_pump.rf_fast_acquire)
    else $error("turbo kept after lock");
endmodule : twr_bank_props

/* bench/twr_host_model.sv */
/*
  twr_host_model: serial host that loads words into the bank.
  assumes: tasks called from the bench; changes only on falling ref edges.
*/
`timescale 1ns/1ps
module twr_host_model (
  input wire logic i_ref_clk,
  output logic o_sclk,
  output logic o_sdata,
  output logic o_sel_n
);
  initial begin
    o_sclk = 1'b0;
    o_sdata = 1'b0;
    o_sel_n = 1'b1;
  end

  // half of a 64 ns link period
  task automatic half;
    repeat (4) @(negedge i_ref_clk);
  endtask : half

  // bit count is free so the bench can send bad lengths on purpose
  task automatic send(input logic [23:0] w, input int n, input logic sel);
    o_sel_n = sel;
    half();
    for (int i = 0; i < n; i++) begin
      o_sdata = w[23 - (i % 24)];
      o_sclk = 1'b0;
      half();
      o_sclk = 1'b1;
      half();
    end
    o_sclk = 1'b0;
    half();
    o_sel_n = 1'b1;
    // released data line: show the inverse so a stale value never matches
    o_sdata = ~o_sdata;
    repeat (8) @(negedge i_ref_clk);
  endtask : send
endmodule : twr_host_model

/* hdl/twr_fast_acquire.sv */
/*
  twr_fast_acquire: charge-pump turbo window for one pll.
  assumes: i_phase_lead and i_locked are already synchronised to i_ref_clk;
  i_start is a one-cycle pulse on the same clock.
*/
`timescale 1ns/1ps
module twr_fast_acquire (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_enable,
  input wire logic i_hold_max,
  input wire logic i_start,
  input wire logic i_phase_lead,
  input wire logic i_locked,
  output logic o_turbo
);

  typedef struct packed {
    logic active;
    logic prev_lead;
    logic [1:0] flips;
    logic turbo;
  } twr_fa_state_t;

  twr_fa_state_t state_reg;
  twr_fa_state_t state_next;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    state_next.prev_lead = i_phase_lead;
    if (i_start) begin
      state_next.active = 1'b1;
      state_next.flips = 2'h0;
    end else if (state_reg.active) begin
      if (i_locked) begin
        state_next.active = 1'b0;
      end else if (i_phase_lead != state_reg.prev_lead) begin
        // lead->lag and lag->lead both count
        state_next.flips = state_reg.flips + 2'h1;
        if (state_reg.flips == 2'h1) begin
          state_next.active = 1'b0;
        end
      end
    end
    // hold-max keeps the boost past lock; without enable it has no effect
    state_next.turbo = i_enable & (state_next.active | i_hold_max);
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_turbo = state_reg.turbo;

endmodule : twr_fast_acquire

/* hdl/twr_pkg.sv */
/*
  twr_pkg: constants and carrier types for the three-wire register bank.
  assumes: used by twr_register_bank and the bench, always as twr_pkg::name.
*/
package twr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // serial word layout
  localparam int WORD_W = 24;
  localparam int DATA_W = 20;
  localparam int ADDR_W = 4;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] WORD_BITS = 5'h18;

  ////////////////////////////////////////////////////////////////////////////
  // register addresses
  localparam logic [ADDR_W-1:0] ADDR_RF_MAIN = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_RF_REF = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_IF_MAIN = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_IF_REF = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_OP_CTRL = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_SETUP = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_TEST = 4'h7;

  ////////////////////////////////////////////////////////////////////////////
  // power-up values (172087, 1968, 6519, 492 decimal)
  localparam logic [DATA_W-1:0] RST_RF_MAIN = 20'h2_a037;
  localparam logic [DATA_W-1:0] RST_RF_REF = 20'h0_07b0;
  localparam logic [DATA_W-1:0] RST_IF_MAIN = 20'h0_1977;
  localparam logic [DATA_W-1:0] RST_IF_REF = 20'h0_01ec;
  localparam logic [DATA_W-1:0] RST_OP_CTRL = 20'h0_892f;
  localparam logic [DATA_W-1:0] RST_SETUP = 20'h0_d03f;
  localparam logic [DATA_W-1:0] RST_TEST = 20'h0_0000;

  ////////////////////////////////////////////////////////////////////////////
  // divide-ratio field widths
  localparam int RF_MAIN_W = 18;
  localparam int RF_REF_W = 13;
  localparam int IF_MAIN_W = 14;
  localparam int IF_REF_W = 11;

  ////////////////////////////////////////////////////////////////////////////
  // operation_control bit positions
  localparam int OP_SOFT_POWER_OFF = 0;
  localparam int OP_STANDBY_KEEP_REGS = 2;
  localparam int OP_BUF_ENABLE = 4;
  localparam int OP_IF_VCO_HIGH = 9;
  localparam int OP_IF_PORT_HIGH = 10;
  localparam int OP_IF_HOLD_MAX = 13;
  localparam int OP_RF_HOLD_MAX = 14;

  // pll_setup_options bit positions
  localparam int CF_RF_FAST_ACQUIRE = 2;
  localparam int CF_IF_FAST_ACQUIRE = 3;
  localparam int CF_RF_PUMP_LO = 6;
  localparam int CF_IF_PUMP_LO = 8;
  localparam int CF_BUF_DIV2 = 11;
  localparam int PUMP_W = 2;

  ////////////////////////////////////////////////////////////////////////////
  // synchroniser lanes
  localparam int SY_SCLK = 0;
  localparam int SY_SDATA = 1;
  localparam int SY_SEL_N = 2;
  localparam int SY_PWR_N = 3;
  localparam int SY_IF_LEAD = 4;
  localparam int SY_IF_LOCK = 5;
  localparam int SY_RF_LEAD = 6;
  localparam int SY_RF_LOCK = 7;
  localparam int SY_W = 8;

  // pll index for the fast-acquire pair
  localparam int PLL_IF = 0;
  localparam int PLL_RF = 1;
  localparam int NUM_PLL = 2;

  typedef struct packed {
    logic [DATA_W-1:0] rf_main_divider;
    logic [DATA_W-1:0] rf_reference_divider;
    logic [DATA_W-1:0] if_main_divider;
    logic [DATA_W-1:0] if_reference_divider;
    logic [DATA_W-1:0] operation_control;
    logic [DATA_W-1:0] pll_setup_options;
    logic [DATA_W-1:0] test_mode_control;
  } twr_regs_t;

  localparam twr_regs_t REGS_DEFAULT = '{
    rf_main_divider: RST_RF_MAIN,
    rf_reference_divider: RST_RF_REF,
    if_main_divider: RST_IF_MAIN,
    if_reference_divider: RST_IF_REF,
    operation_control: RST_OP_CTRL,
    pll_setup_options: RST_SETUP,
    test_mode_control: RST_TEST
  };

  typedef struct packed {
    logic [RF_MAIN_W-1:0] rf_main_ratio;
    logic [RF_REF_W-1:0] rf_ref_ratio;
    logic [IF_MAIN_W-1:0] if_main_ratio;
    logic [IF_REF_W-1:0] if_ref_ratio;
  } twr_ratios_t;

  typedef struct packed {
    logic [PUMP_W-1:0] if_pump_current;
    logic [PUMP_W-1:0] rf_pump_current;
    logic if_fast_acquire;
    logic rf_fast_acquire;
  } twr_pump_t;

endpackage : twr_pkg

/* hdl/twr_register_bank.sv */
/*
  twr_register_bank: serially loaded control registers of the transmitter.
  assumes: serial clock, data, select, power-off pin and pll phase/lock levels
  are asynchronous to i_ref_clk and far slower than it (serial clock >= 8 ref cycles).
*/
// Functional notes
// - words are exactly 24 bits, one per register
// - low 4 bits address, upper 20 data
// - shift data on serial clock rise, select low
// - select rising copies word to addressed register
// - unused data bits have no effect
// - divider defaults 172087, 1968, 6519, 492
// - control defaults 892f, d03f, 0000 hex
// - addresses 0-3 dividers, 4 control, 5 setup, 7 test
// - rf main ratio from bits 17..0
// - rf reference ratio from bits 12..0
// - if dividers set if ratios likewise
// - lo buffer on only when enable bit set
// - lo buffer divide bit halves frequency
// - turbo enable gives max pump during acquisition
// - turbo ends after second lead/lag change
// - turbo ends at lock, then programmed pump current
// - soft off: all off but serial interface
// - power-off pin low turns everything off
// - either shutdown loses register contents
// - standby powers down but keeps registers
// - vco band independent of if port
// - soft off bit0 restores power-up values
// - standby bit2 spares registers and serial
`timescale 1ns/1ps
module twr_register_bank #(
  parameter int DATA_W = twr_pkg::DATA_W,
  parameter int ADDR_W = twr_pkg::ADDR_W
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_sclk,
  input wire logic i_sdata,
  input wire logic i_sel_n,
  input wire logic i_power_off_pin_n,
  input wire logic i_if_phase_lead,
  input wire logic i_if_locked,
  input wire logic i_rf_phase_lead,
  input wire logic i_rf_locked,
  output twr_pkg::twr_regs_t o_regs,
  output twr_pkg::twr_ratios_t o_ratios,
  output twr_pkg::twr_pump_t o_pump,
  output logic o_serial_active,
  output logic o_functions_on,
  output logic o_buffered_lo_output_en,
  output logic o_buffered_lo_div2,
  output logic o_if_vco_high,
  output logic o_if_port_high
);

  // the word layout is fixed by the analog side; other widths are refused
  if (DATA_W != twr_pkg::DATA_W || ADDR_W != twr_pkg::ADDR_W) begin : g_width_check
    $error("twr_register_bank: only 20 data and 4 address bits are supported");
  end

  typedef struct packed {
    logic [twr_pkg::SY_W-1:0] sync1;
    logic [twr_pkg::SY_W-1:0] sync2;
    logic [twr_pkg::SY_W-1:0] prev;
    logic [twr_pkg::WORD_W-1:0] shift;
    logic [twr_pkg::CNT_W-1:0] count;
    twr_pkg::twr_regs_t regs;
    logic soft_off;
    logic [twr_pkg::NUM_PLL-1:0] start;
  } twr_state_t;

  twr_state_t state_reg;
  twr_state_t state_next;

  logic [twr_pkg::SY_W-1:0] async_in;
  logic [twr_pkg::NUM_PLL-1:0] fa_enable;
  logic [twr_pkg::NUM_PLL-1:0] fa_hold;
  logic [twr_pkg::NUM_PLL-1:0] fa_lead;
  logic [twr_pkg::NUM_PLL-1:0] fa_lock;
  logic [twr_pkg::NUM_PLL-1:0] fa_turbo;
  logic pin_on;
  logic sclk_rise;
  logic sel_low;
  logic sel_rise;
  logic [ADDR_W-1:0] word_addr;
  logic [DATA_W-1:0] word_data;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers: stage one feeds only stage two
  always_comb begin
    async_in = '0;
    async_in[twr_pkg::SY_SCLK] = i_sclk;
    async_in[twr_pkg::SY_SDATA] = i_sdata;
    async_in[twr_pkg::SY_SEL_N] = i_sel_n;
    async_in[twr_pkg::SY_PWR_N] = i_power_off_pin_n;
    async_in[twr_pkg::SY_IF_LEAD] = i_if_phase_lead;
    async_in[twr_pkg::SY_IF_LOCK] = i_if_locked;
    async_in[twr_pkg::SY_RF_LEAD] = i_rf_phase_lead;
    async_in[twr_pkg::SY_RF_LOCK] = i_rf_locked;
  end

  assign pin_on = state_reg.sync2[twr_pkg::SY_PWR_N];
  assign sel_low = ~state_reg.sync2[twr_pkg::SY_SEL_N];
  // data and clock share the same sync delay, so the sampled bit lines up
  assign sclk_rise = state_reg.sync2[twr_pkg::SY_SCLK] & ~state_reg.prev[twr_pkg::SY_SCLK];
  assign sel_rise = state_reg.sync2[twr_pkg::SY_SEL_N] & ~state_reg.prev[twr_pkg::SY_SEL_N];
  assign word_addr = state_reg.shift[ADDR_W-1:0];
  assign word_data = state_reg.shift[twr_pkg::WORD_W-1:ADDR_W];

  ////////////////////////////////////////////////////////////////////////////
  // shift, latch and power-state logic
  always_comb begin
    state_next = state_reg;
    state_next.sync1 = async_in;
    state_next.sync2 = state_reg.sync1;
    state_next.prev = state_reg.sync2;
    state_next.start = '0;
    if (!pin_on) begin
      // pin low: serial port dead and contents lost
      state_next.regs = twr_pkg::REGS_DEFAULT;
      state_next.shift = '0;
      state_next.count = '0;
      state_next.soft_off = 1'b0;
    end else begin
      if (sel_low && sclk_rise) begin
        state_next.shift = {state_reg.shift[twr_pkg::WORD_W-2:0], state_reg.sync2[twr_pkg::SY_SDATA]};
        // count saturates above 24 so an overlong word is never taken
        if (state_reg.count <= twr_pkg::WORD_BITS) begin
          state_next.count = state_reg.count + 5'h01;
        end
      end
      if (sel_rise) begin
        state_next.count = '0;
        if (state_reg.count == twr_pkg::WORD_BITS) begin
          case (word_addr)
            twr_pkg::ADDR_RF_MAIN: begin
              state_next.regs.rf_main_divider = word_data;
              state_next.start[twr_pkg::PLL_RF] = 1'b1;
            end
            twr_pkg::ADDR_RF_REF: begin
              state_next.regs.rf_reference_divider = word_data;
              state_next.start[twr_pkg::PLL_RF] = 1'b1;
            end
            twr_pkg::ADDR_IF_MAIN: begin
              state_next.regs.if_main_divider = word_data;
              state_next.start[twr_pkg::PLL_IF] = 1'b1;
            end
            twr_pkg::ADDR_IF_REF: begin
              state_next.regs.if_reference_divider = word_data;
              state_next.start[twr_pkg::PLL_IF] = 1'b1;
            end
            twr_pkg::ADDR_OP_CTRL: begin
              if (!word_data[twr_pkg::OP_SOFT_POWER_OFF]) begin
                // soft off: contents back to power-up, serial stays alive
                state_next.regs = twr_pkg::REGS_DEFAULT;
                state_next.soft_off = 1'b1;
              end else begin
                state_next.regs.operation_control = word_data;
                state_next.soft_off = 1'b0;
                state_next.start = '1;
              end
            end
            twr_pkg::ADDR_SETUP: begin
              state_next.regs.pll_setup_options = word_data;
            end
            twr_pkg::ADDR_TEST: begin
              state_next.regs.test_mode_control = word_data;
            end
            default: begin
              // unmapped word is dropped untouched
              state_next.regs = state_reg.regs;
            end
          endcase
        end
      end else if (!sel_low) begin
        // bits clocked while deselected are ignored
        state_next.count = '0;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg.sync1 <= '0;
      state_reg.sync2 <= '0;
      state_reg.prev <= '0;
      state_reg.shift <= '0;
      state_reg.count <= '0;
      state_reg.regs <= twr_pkg::REGS_DEFAULT;
      state_reg.soft_off <= 1'b0;
      state_reg.start <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decoded controls; standby gates functions but never touches registers
  assign o_regs = state_reg.regs;
  assign o_serial_active = pin_on;
  assign o_functions_on = pin_on & ~state_reg.soft_off
    & state_reg.regs.operation_control[twr_pkg::OP_STANDBY_KEEP_REGS];

  // only the documented ratio bits are forwarded; the rest are don't care
  assign o_ratios.rf_main_ratio = state_reg.regs.rf_main_divider[twr_pkg::RF_MAIN_W-1:0];
  assign o_ratios.rf_ref_ratio = state_reg.regs.rf_reference_divider[twr_pkg::RF_REF_W-1:0];
  assign o_ratios.if_main_ratio = state_reg.regs.if_main_divider[twr_pkg::IF_MAIN_W-1:0];
  assign o_ratios.if_ref_ratio = state_reg.regs.if_reference_divider[twr_pkg::IF_REF_W-1:0];

  assign o_buffered_lo_output_en = o_functions_on
    & state_reg.regs.operation_control[twr_pkg::OP_BUF_ENABLE];
  assign o_buffered_lo_div2 = state_reg.regs.pll_setup_options[twr_pkg::CF_BUF_DIV2];
  // two separate bits, no cross-coupling
  assign o_if_vco_high = state_reg.regs.operation_control[twr_pkg::OP_IF_VCO_HIGH];
  assign o_if_port_high = state_reg.regs.operation_control[twr_pkg::OP_IF_PORT_HIGH];

  assign o_pump.if_pump_current =
    state_reg.regs.pll_setup_options[twr_pkg::CF_IF_PUMP_LO +: twr_pkg::PUMP_W];
  assign o_pump.rf_pump_current =
    state_reg.regs.pll_setup_options[twr_pkg::CF_RF_PUMP_LO +: twr_pkg::PUMP_W];
  assign o_pump.if_fast_acquire = fa_turbo[twr_pkg::PLL_IF];
  assign o_pump.rf_fast_acquire = fa_turbo[twr_pkg::PLL_RF];

  ////////////////////////////////////////////////////////////////////////////
  // fast-acquire windows, one per pll
  assign fa_enable[twr_pkg::PLL_IF] = o_functions_on
    & state_reg.regs.pll_setup_options[twr_pkg::CF_IF_FAST_ACQUIRE];
  assign fa_enable[twr_pkg::PLL_RF] = o_functions_on
    & state_reg.regs.pll_setup_options[twr_pkg::CF_RF_FAST_ACQUIRE];
  assign fa_hold[twr_pkg::PLL_IF] = state_reg.regs.operation_control[twr_pkg::OP_IF_HOLD_MAX];
  assign fa_hold[twr_pkg::PLL_RF] = state_reg.regs.operation_control[twr_pkg::OP_RF_HOLD_MAX];
  assign fa_lead[twr_pkg::PLL_IF] = state_reg.sync2[twr_pkg::SY_IF_LEAD];
  assign fa_lead[twr_pkg::PLL_RF] = state_reg.sync2[twr_pkg::SY_RF_LEAD];
  assign fa_lock[twr_pkg::PLL_IF] = state_reg.sync2[twr_pkg::SY_IF_LOCK];
  assign fa_lock[twr_pkg::PLL_RF] = state_reg.sync2[twr_pkg::SY_RF_LOCK];

  for (genvar g = 0; g < twr_pkg::NUM_PLL; g++) begin : g_pll
    twr_fast_acquire twr_fast_acquire_i (
      .i_ref_clk(i_ref_clk),
      .i_arst_n(i_arst_n),
      .i_enable(fa_enable[g]),
      .i_hold_max(fa_hold[g]),
      .i_start(state_reg.start[g]),
      .i_phase_lead(fa_lead[g]),
      .i_locked(fa_lock[g]),
      .o_turbo(fa_turbo[g])
    );
  end

endmodule : twr_register_bank
